// ---- verilog/tof_pixel_output_formatter.sv ----
// pixel output port sequencer with apb configuration registers
//
// Notes on behaviour
// - slow stretch bit adds 2 us per row
// - high-first split sends msb then lsb byte
// - low-first split sends lsb then msb byte
// - byte-only format sends upper eight bits
// - format field selects one of three formats
// - split formats keep row valid twice as long
// - high-first hardware sync byte layout with sat
// - low-first hardware sync byte layout with sat
// - byte-only hardware sync sends bits 11..4
// - saturation insert on line 0, split only
// - force all ones for saturated pixel
// - embedded sync drops lines, adds labels
// - label is ff, 00, 00, designator
// - default designators 1e, e1, aa, 55
// - designators come from registers 1c..1f
// - embedded image bytes stay within 01..fe
// - idle and reset bus value is 01
// - embedded high-first byte layout
// - embedded low-first byte layout
// - embedded byte-only sends bits 11..4
// - pixels are 12-bit signed with sat flag
// - outputs change on active output clock edge
// - extra line carries sat or frame end
`timescale 1ns/1ps
`include "tof_fmt_defs.svh"
module tof_pixel_output_formatter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pix_valid,
	input wire logic signed [11:0] pix_value,
	input wire logic pix_sat,
	input wire logic pix_first_in_frame,
	input wire logic pix_last_in_row,
	input wire logic pix_last_in_frame,
	output logic pix_take,
	output logic pixel_output_clock,
	output logic [7:0] pixel_output_port,
	output logic frame_valid_line,
	output logic row_valid_line,
	output logic saturation_or_frame_end_line
);
	import tof_fmt_pkg::*;

	localparam logic [7:0] STRETCH_LAST = 8'(`STRETCH_CYC - 1);

	// register hit and read value for one word index
	function automatic logic [8:0] reg_lookup(
		input logic [9:0] idx,
		input logic [7:0] status,
		input logic [7:0] clkdiv,
		input logic [7:0] slow,
		input logic [7:0] cfg,
		input logic [7:0] cfg2,
		input logic [31:0] lbl
	);
		case (idx)
			`IDX_STATUS: reg_lookup = {1'b1, status};
			`IDX_CLKDIV: reg_lookup = {1'b1, clkdiv};
			`IDX_SLOW: reg_lookup = {1'b1, slow};
			`IDX_CFG: reg_lookup = {1'b1, cfg};
			`IDX_CFG2: reg_lookup = {1'b1, cfg2};
			`IDX_LBL_FS: reg_lookup = {1'b1, lbl[7:0]};
			`IDX_LBL_FE: reg_lookup = {1'b1, lbl[15:8]};
			`IDX_LBL_LS: reg_lookup = {1'b1, lbl[23:16]};
			`IDX_LBL_LE: reg_lookup = {1'b1, lbl[31:24]};
			default: reg_lookup = 9'h000;
		endcase
	endfunction : reg_lookup

	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0] clkdiv_q;
	logic [7:0] slow_q;
	logic [7:0] cfg_q;
	logic [7:0] cfg2_q;
	logic [31:0] lbl_q;
	logic [7:0] div_cnt_q;
	logic oclk_q;
	seq_state_t state_q;
	seq_state_t state_d;
	label_kind_t kind_q;
	label_kind_t kind_d;
	logic [1:0] idx_q;
	logic [1:0] idx_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic fv_q;
	logic fv_d;
	logic rv_q;
	logic rv_d;
	logic xs_q;
	logic xs_d;
	logic take_q;
	logic take_d;
	logic [11:0] hold_px_q;
	logic hold_sat_q;
	logic hold_eol_q;
	logic hold_eof_q;
	logic [7:0] str_cnt_q;
	logic str_done_q;
	logic [8:0] lookup;
	logic [7:0] status;
	logic [7:0] div_eff;
	logic access;
	logic wr_fire;
	logic tick;
	logic embedded_sync_mode;
	logic xsat_mode;
	logic last_byte;
	byte_format_t fmt;

	pixel_map_if pm ();

	pixel_byte_mapper u_mapper (
		.m(pm.mapper)
	);

	assign embedded_sync_mode = cfg_q[`CFG_ESM_BIT];
	assign xsat_mode = cfg2_q[`CFG2_XSAT_BIT];
	assign fmt = byte_format_t'(cfg_q[`CFG_FMT_MSB:`CFG_FMT_LSB]);
	assign status = {2'b00, state_q, fv_q, rv_q, oclk_q};
	assign lookup = reg_lookup(paddr[11:2], status, clkdiv_q, slow_q, cfg_q,
		cfg2_q, lbl_q);
	assign access = psel && penable;
	assign wr_fire = access && pready_q && pwrite;

	// apb answer, one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (access && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= ~lookup[8];
			prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, lookup[7:0]};
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkdiv_q <= `CLKDIV_RST;
			slow_q <= `SLOW_RST;
			cfg_q <= `CFG_RST;
			cfg2_q <= `CFG2_RST;
			lbl_q <= {`LBL_LE_RST, `LBL_LS_RST, `LBL_FE_RST, `LBL_FS_RST};
		end else if (wr_fire) begin
			case (paddr[11:2])
				`IDX_CLKDIV: clkdiv_q <= pwdata[7:0];
				`IDX_SLOW: slow_q <= pwdata[7:0];
				`IDX_CFG: cfg_q <= pwdata[7:0];
				`IDX_CFG2: cfg2_q <= pwdata[7:0];
				`IDX_LBL_FS: lbl_q[7:0] <= pwdata[7:0];
				`IDX_LBL_FE: lbl_q[15:8] <= pwdata[7:0];
				`IDX_LBL_LS: lbl_q[23:16] <= pwdata[7:0];
				`IDX_LBL_LE: lbl_q[31:24] <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// output clock divider and active edge strobe
	assign div_eff = (clkdiv_q == 8'h00) ? 8'h01 : clkdiv_q;
	assign tick = (div_cnt_q >= div_eff) && (oclk_q != cfg2_q[`CFG2_POL_BIT]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 8'h00;
			oclk_q <= 1'b0;
		end else if (div_cnt_q >= div_eff) begin
			div_cnt_q <= 8'h00;
			oclk_q <= ~oclk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	// slow interface row stretch timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			str_cnt_q <= 8'h00;
			str_done_q <= 1'b0;
		end else if (state_q != S_STRETCH) begin
			str_cnt_q <= STRETCH_LAST;
			str_done_q <= 1'b0;
		end else if (str_cnt_q != 8'h00) begin
			str_cnt_q <= str_cnt_q - 8'h01;
		end else begin
			str_done_q <= 1'b1;
		end
	end

	// mapper input: live pixel on the first byte, held one on the second
	always_comb begin
		pm.px = (state_q == S_BYTE1) ? hold_px_q : pix_value;
		pm.pixel_saturation_flag = (state_q == S_BYTE1) ? hold_sat_q : pix_sat;
		pm.fmt = fmt;
		pm.embedded_sync_mode = embedded_sync_mode;
		pm.sat_ins = cfg_q[`CFG_SATINS_BIT] && (fmt != FMT_BYTE_ONLY);
		pm.force_sat = cfg2_q[`CFG2_FORCE_BIT];
	end

	// next output word, evaluated at each active edge
	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		idx_d = idx_q;
		data_d = `IDLE_BYTE;
		fv_d = fv_q;
		rv_d = rv_q;
		xs_d = 1'b0;
		take_d = 1'b0;
		last_byte = 1'b0;
		case (state_q)
			S_IDLE: begin
				rv_d = 1'b0;
				if (pix_valid && embedded_sync_mode) begin
					state_d = S_LABEL;
					idx_d = 2'b00;
					kind_d = pix_first_in_frame ? LBL_FS : LBL_LS;
				end else if (pix_valid) begin
					take_d = 1'b1;
					fv_d = fv_q | pix_first_in_frame;
					rv_d = 1'b1;
				end
			end
			S_BYTE0: begin
				take_d = pix_valid;
			end
			S_BYTE1: begin
				data_d = pm.second_b;
				xs_d = hold_sat_q;
				last_byte = hold_eol_q;
				state_d = hold_eol_q ? S_BYTE1 : S_BYTE0;
			end
			S_LABEL: begin
				case (idx_q)
					2'b00: data_d = `LABEL_HEAD;
					2'b11: data_d = lbl_q[8*kind_q +: 8];
					default: data_d = `LABEL_PAD;
				endcase
				idx_d = idx_q + 2'b01;
				if (idx_q == 2'b11) begin
					case (kind_q)
						LBL_FS: kind_d = LBL_LS;
						LBL_LS: state_d = S_BYTE0;
						LBL_LE: begin
							kind_d = LBL_FE;
							state_d = hold_eof_q ? S_LABEL : S_IDLE;
						end
						default: state_d = S_IDLE;
					endcase
				end
			end
			S_STRETCH: begin
				if (str_done_q) begin
					state_d = S_ROWEND;
				end
			end
			S_ROWEND: begin
				rv_d = 1'b0;
				state_d = S_IDLE;
				if (hold_eof_q) begin
					fv_d = 1'b0;
					xs_d = 1'b1;
				end
			end
			default: state_d = S_IDLE;
		endcase
		if (take_d) begin
			data_d = pm.first_b;
			xs_d = pix_sat;
			if (fmt == FMT_BYTE_ONLY) begin
				last_byte = pix_last_in_row;
				state_d = S_BYTE0;
			end else begin
				state_d = S_BYTE1;
			end
		end
		if (last_byte) begin
			idx_d = 2'b00;
			kind_d = LBL_LE;
			if (embedded_sync_mode) begin
				state_d = S_LABEL;
			end else if (slow_q[`SLOW_STRETCH_BIT]) begin
				state_d = S_STRETCH;
			end else begin
				state_d = S_ROWEND;
			end
		end
		if (xsat_mode) begin
			xs_d = xs_d && (state_q != S_ROWEND);
		end else begin
			xs_d = xs_d && (state_q == S_ROWEND);
		end
		if (embedded_sync_mode) begin
			fv_d = 1'b0;
			rv_d = 1'b0;
			xs_d = 1'b0;
		end
	end

	// sequencer state, held pixel and output lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			kind_q <= LBL_FS;
			idx_q <= 2'b00;
			data_q <= `IDLE_BYTE;
			fv_q <= 1'b0;
			rv_q <= 1'b0;
			xs_q <= 1'b0;
		end else if (tick) begin
			state_q <= state_d;
			kind_q <= kind_d;
			idx_q <= idx_d;
			data_q <= data_d;
			fv_q <= fv_d;
			rv_q <= rv_d;
			xs_q <= xs_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			take_q <= 1'b0;
			hold_px_q <= 12'h000;
			hold_sat_q <= 1'b0;
			hold_eol_q <= 1'b0;
			hold_eof_q <= 1'b0;
		end else begin
			take_q <= tick && take_d;
			if (tick && take_d) begin
				hold_px_q <= pix_value;
				hold_sat_q <= pix_sat;
				hold_eol_q <= pix_last_in_row;
				hold_eof_q <= pix_last_in_frame;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pix_take = take_q;
	assign pixel_output_clock = oclk_q;
	assign pixel_output_port = data_q;
	assign frame_valid_line = fv_q;
	assign row_valid_line = rv_q;
	assign saturation_or_frame_end_line = xs_q;
endmodule : tof_pixel_output_formatter

// ---- verilog/tof_fmt_defs.svh ----
// register indices, field positions, reset values and timing counts
`ifndef TOF_FMT_DEFS_SVH
`define TOF_FMT_DEFS_SVH

`define IDX_STATUS 10'h000
`define IDX_CLKDIV 10'h089
`define IDX_SLOW 10'h091
`define IDX_CFG 10'h0CB
`define IDX_CFG2 10'h0CC
`define IDX_LBL_FS 10'h01C
`define IDX_LBL_FE 10'h01D
`define IDX_LBL_LS 10'h01E
`define IDX_LBL_LE 10'h01F

`define SLOW_STRETCH_BIT 6
`define CFG_FMT_LSB 0
`define CFG_FMT_MSB 1
`define CFG_ESM_BIT 2
`define CFG_SATINS_BIT 6
`define CFG2_POL_BIT 0
`define CFG2_XSAT_BIT 6
`define CFG2_FORCE_BIT 7

`define CLKDIV_RST 8'h01
`define SLOW_RST 8'h00
`define CFG_RST 8'h00
`define CFG2_RST 8'h41
`define LBL_FS_RST 8'h1E
`define LBL_FE_RST 8'hE1
`define LBL_LS_RST 8'hAA
`define LBL_LE_RST 8'h55

`define IDLE_BYTE 8'h01
`define LABEL_HEAD 8'hFF
`define LABEL_PAD 8'h00
`define SAT_FORCE_VAL 12'hFFF

`define PCLK_PERIOD_PS 8000
`define STRETCH_NS 2000
`define STRETCH_CYC ((`STRETCH_NS * 1000) / `PCLK_PERIOD_PS)

`endif

// ---- verilog/tof_fmt_pkg.sv ----
// types shared by the pixel output formatter
package tof_fmt_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_BYTE0 = 3'b001,
		S_BYTE1 = 3'b010,
		S_LABEL = 3'b011,
		S_STRETCH = 3'b100,
		S_ROWEND = 3'b101
	} seq_state_t;
	typedef enum logic [1:0] {
		LBL_FS = 2'b00,
		LBL_FE = 2'b01,
		LBL_LS = 2'b10,
		LBL_LE = 2'b11
	} label_kind_t;
	typedef enum logic [1:0] {
		FMT_HI_FIRST = 2'b00,
		FMT_LO_FIRST = 2'b01,
		FMT_BYTE_ONLY = 2'b10
	} byte_format_t;
endpackage : tof_fmt_pkg

// ---- verilog/pixel_map_if.sv ----
// pixel to byte mapping signals between sequencer and mapper
`timescale 1ns/1ps
interface pixel_map_if;
	import tof_fmt_pkg::*;
	logic [11:0] px;
	logic pixel_saturation_flag;
	byte_format_t fmt;
	logic embedded_sync_mode;
	logic sat_ins;
	logic force_sat;
	logic [7:0] first_b;
	logic [7:0] second_b;
	modport seq (output px, pixel_saturation_flag, fmt, embedded_sync_mode, sat_ins, force_sat,
		input first_b, second_b);
	modport mapper (input px, pixel_saturation_flag, fmt, embedded_sync_mode, sat_ins, force_sat,
		output first_b, second_b);
endinterface : pixel_map_if

// ---- verilog/pixel_byte_mapper.sv ----
// maps one pixel and its saturation flag onto the two bus bytes
`timescale 1ns/1ps
`include "tof_fmt_defs.svh"
module pixel_byte_mapper (
	pixel_map_if.mapper m
);
	import tof_fmt_pkg::*;

	function automatic logic [7:0] keep_off_labels(input logic [7:0] b);
		if (b == `LABEL_HEAD) begin
			keep_off_labels = 8'hFE;
		end else if (b == `LABEL_PAD) begin
			keep_off_labels = `IDLE_BYTE;
		end else begin
			keep_off_labels = b;
		end
	endfunction : keep_off_labels

	logic [11:0] v;
	logic [7:0] hw_hi;
	logic [7:0] hw_lo;
	logic [7:0] es_hi;
	logic [7:0] es_lo;

	always_comb begin
		v = (m.force_sat && m.pixel_saturation_flag) ? `SAT_FORCE_VAL : m.px;
		hw_hi = v[11:4];
		hw_lo = {v[3:0], 3'b000, m.sat_ins & m.pixel_saturation_flag};
		es_hi = {2'b01, v[11:6]};
		es_lo = {v[5:0], m.pixel_saturation_flag, ~m.pixel_saturation_flag};
		m.first_b = hw_hi;
		m.second_b = hw_hi;
		case (m.fmt)
			FMT_HI_FIRST: begin
				m.first_b = m.embedded_sync_mode ? es_hi : hw_hi;
				m.second_b = m.embedded_sync_mode ? es_lo : hw_lo;
			end
			FMT_LO_FIRST: begin
				m.first_b = m.embedded_sync_mode ? es_lo : hw_lo;
				m.second_b = m.embedded_sync_mode ? es_hi : hw_hi;
			end
			default: begin
				m.first_b = m.embedded_sync_mode ? keep_off_labels(hw_hi) : hw_hi;
				m.second_b = m.first_b;
			end
		endcase
	end
endmodule : pixel_byte_mapper

// ---- dv/fmt_properties.sv ----
// port assertions for the pixel output formatter
`timescale 1ns/1ps
module fmt_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pix_take,
	input wire logic pixel_output_clock,
	input wire logic [7:0] pixel_output_port,
	input wire logic frame_valid_line,
	input wire logic row_valid_line
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence tick;
		$rose(pixel_output_clock);
	endsequence
	sequence out_moved;
		$changed(pixel_output_port) || $changed(row_valid_line) ||
			$changed(frame_valid_line);
	endsequence
	sequence after_head;
		$changed(pixel_output_port) && $past(pixel_output_port) == 8'hff &&
			!$past(frame_valid_line);
	endsequence
	chk_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb access not answered after one wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response without ready or with data");
	chk_take_tick: assert property (pix_take |-> tick)
		else $error("pixel taken off the active output clock edge");
	chk_edge_only: assert property (out_moved |-> tick)
		else $error("bus or sync line moved off the active edge");
	chk_label_pad: assert property (after_head |-> pixel_output_port == 8'h00)
		else $error("label head not followed by pad byte");
	chk_reset_idle: assert property ($rose(presetn) |->
		pixel_output_port == 8'h01 && !row_valid_line)
		else $error("bus not idle after reset");
	chk_row_in_frame: assert property (row_valid_line |-> frame_valid_line)
		else $error("row valid outside frame valid");
endmodule : fmt_properties

bind tof_pixel_output_formatter fmt_properties chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pix_take(pix_take),
	.pixel_output_clock(pixel_output_clock),
	.pixel_output_port(pixel_output_port),
	.frame_valid_line(frame_valid_line), .row_valid_line(row_valid_line));

// ---- dv/pixel_rx_model.sv ----
// capturing receiver: samples the bus on the non-active clock edge
`timescale 1ns/1ps
module pixel_rx_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic oclk,
	input wire logic [7:0] port,
	input wire logic rv,
	input wire logic [7:0] ls_code,
	input wire logic [7:0] le_code,
	output logic cap_stb,
	output logic [7:0] cap_byte,
	output logic cap_rv,
	output logic row_open
);
	logic oclk_q;
	logic [23:0] hist_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oclk_q <= 1'b0;
			cap_stb <= 1'b0;
			cap_byte <= 8'h00;
			cap_rv <= 1'b0;
		end else begin
			oclk_q <= oclk;
			cap_stb <= oclk_q && !oclk;
			cap_byte <= port;
			cap_rv <= rv;
		end
	end
	// label scan, image kept between row labels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_q <= 24'h00_0000;
			row_open <= 1'b0;
		end else if (cap_stb) begin
			hist_q <= {hist_q[15:0], cap_byte};
			if ({hist_q, cap_byte} == {24'hff_0000, ls_code})
				row_open <= 1'b1;
			else if ({hist_q, cap_byte} == {24'hff_0000, le_code})
				row_open <= 1'b0;
		end
	end
endmodule : pixel_rx_model

// ---- dv/tb_top.sv ----
// self-checking bench for the pixel output formatter
`timescale 1ns/1ps
`include "tof_fmt_defs.svh"
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed, r;
	logic pix_valid, pix_sat, pix_first_in_frame, pix_last_in_row;
	logic pix_last_in_frame, pix_take, oclk, fv, rv, xsat;
	logic signed [11:0] pix_value;
	logic [7:0] port, cap_byte;
	logic cap_stb, cap_rv, row_open, coll, esm_run, started;
	logic [7:0] lbl [4];
	logic [7:0] got [$];
	logic [7:0] exp_q [$];
	logic [9:0] ridx [8];
	logic [7:0] rrst [8];
	int n_fail, total_checks, rv_cyc, i, fv_cyc, xs_cyc, xs_byte, img_n;
	int rvc [7];
	tof_pixel_output_formatter dut_u (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_valid(pix_valid), .pix_value(pix_value),
		.pix_sat(pix_sat), .pix_first_in_frame(pix_first_in_frame),
		.pix_last_in_row(pix_last_in_row),
		.pix_last_in_frame(pix_last_in_frame), .pix_take(pix_take),
		.pixel_output_clock(oclk), .pixel_output_port(port),
		.frame_valid_line(fv), .row_valid_line(rv),
		.saturation_or_frame_end_line(xsat));
	pixel_rx_model rx_u (.pclk(pclk), .presetn(presetn), .oclk(oclk),
		.port(port), .rv(rv), .ls_code(lbl[2]), .le_code(lbl[3]),
		.cap_stb(cap_stb), .cap_byte(cap_byte), .cap_rv(cap_rv),
		.row_open(row_open));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task summarize;
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
			n_fail++;
		end
	endtask : chk
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [15:0] map(input logic [11:0] v, input logic s,
		input logic [1:0] f, input logic m, input logic ins, input logic frc);
		logic [7:0] b;
		if (frc && s) v = `SAT_FORCE_VAL;
		b = v[11:4];
		if (m && b == 8'hff) b = 8'hfe;
		if (m && b == 8'h00) b = 8'h01;
		if (f > 2'h1) return {b, 8'h00};
		if (m && f == 2'h0) return {2'h1, v[11:0], s, ~s};
		if (m) return {v[5:0], s, ~s, 2'h1, v[11:6]};
		if (f == 2'h0) return {v, 3'h0, s & ins};
		return {v[3:0], 3'h0, s & ins, v[11:4]};
	endfunction : map
	task apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'h0};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
		if (k == 50) begin
			n_fail++;
			summarize();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task lab(input logic [7:0] d);
		exp_q.push_back(8'hff);
		exp_q.push_back(8'h00);
		exp_q.push_back(8'h00);
		exp_q.push_back(d);
	endtask : lab
	task wait_take;
		int t;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pix_take !== 1'b1 && t < 2000);
		if (t == 2000) begin
			n_fail++;
			summarize();
		end
	endtask : wait_take
	always @(posedge pclk) begin
		if (coll && rv === 1'b1) rv_cyc++;
		if (coll && fv === 1'b1) fv_cyc++;
		if (coll && xsat === 1'b1) xs_cyc++;
		if (coll && cap_stb === 1'b1) begin
			if (cap_rv === 1'b1 && xsat === 1'b1) xs_byte++;
			if (row_open === 1'b1) img_n++;
			if (esm_run && cap_byte === 8'hff) started = 1'b1;
			if (esm_run ? started && got.size() < exp_q.size()
				: cap_rv === 1'b1) got.push_back(cap_byte);
		end
	end
	task run(input int k);
		logic [1:0] f;
		logic m, ins, frc, s;
		logic [11:0] v;
		logic [15:0] w;
		int j, xs_exp;
		f = 2'(k % 3);
		m = k > 2 && k < 6;
		ins = k % 2 == 1 || k == 2;
		frc = k == 2 || k == 4;
		apb(1'b1, `IDX_CFG, {1'b0, ins, 3'h0, m, f});
		apb(1'b1, `IDX_CFG2, {frc, k == 6 ? 7'h01 : 7'h41});
		apb(1'b1, `IDX_SLOW, k == 6 ? 8'h40 : 8'h00);
		got.delete();
		exp_q.delete();
		started = 1'b0;
		esm_run = m;
		rv_cyc = 0;
		fv_cyc = 0;
		xs_cyc = 0;
		xs_byte = 0;
		img_n = 0;
		xs_exp = 0;
		coll = 1'b1;
		if (m) begin
			lab(lbl[0]);
			lab(lbl[2]);
		end
		for (j = 0; j < 6; j++) begin
			v = j == 0 ? 12'h000 : j == 1 ? 12'hfff : 12'(rnd());
			s = j == 0 ? 1'b1 : j == 1 ? 1'b0 : seed[7];
			w = map(v, s, f, m, ins, frc);
			exp_q.push_back(w[15:8]);
			if (f < 2'h2) exp_q.push_back(w[7:0]);
			if (!m && k != 6 && s) xs_exp += f < 2'h2 ? 2 : 1;
			pix_valid <= 1'b1;
			pix_value <= v;
			pix_sat <= s;
			pix_first_in_frame <= j == 0;
			pix_last_in_row <= j == 5;
			pix_last_in_frame <= j == 5;
			wait_take();
		end
		pix_valid <= 1'b0;
		if (m) begin
			lab(lbl[3]);
			lab(lbl[1]);
		end
		if (k == 6)
			repeat (`STRETCH_CYC / 20 + 1) exp_q.push_back(`IDLE_BYTE);
		for (j = 0; j < 5000 && !(got.size() >= exp_q.size() &&
			rv === 1'b0); j++) @(posedge pclk);
		if (j == 5000) begin
			n_fail++;
			summarize();
		end
		repeat (60) @(posedge pclk);
		coll = 1'b0;
		chk(got.size(), exp_q.size());
		for (j = 0; j < exp_q.size(); j++)
			chk(32'(got[j]), 32'(exp_q[j]));
		if (m) chk(rv_cyc, 0);
		chk(fv_cyc, m ? 0 : rv_cyc);
		chk(xs_byte, xs_exp);
		if (m || k == 6) chk(xs_cyc, k == 6 ? 20 : 0);
		if (m) chk(img_n, f < 2'h2 ? 16 : 10);
		rvc[k] = rv_cyc;
		chk(32'(port), 32'(`IDLE_BYTE));
	endtask : run
	initial begin
		{presetn, psel, penable, pwrite, pix_valid, pix_sat} = 6'h00;
		{pix_first_in_frame, pix_last_in_row, pix_last_in_frame} = 3'h0;
		{paddr, pwdata, pix_value} = 56'h0;
		{coll, esm_run, started} = 3'h0;
		seed = 32'h0000_8ebf;
		n_fail = 0;
		total_checks = 0;
		lbl = '{8'h1e, 8'he1, 8'haa, 8'h55};
		ridx = '{`IDX_CLKDIV, `IDX_SLOW, `IDX_CFG, `IDX_CFG2, `IDX_LBL_FS,
			`IDX_LBL_FE, `IDX_LBL_LS, `IDX_LBL_LE};
		rrst = '{8'h01, 8'h00, 8'h00, 8'h41, 8'h1e, 8'he1, 8'haa, 8'h55};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 8; i++) begin
			apb(1'b0, ridx[i], 8'h00);
			chk(r, {24'h00_0000, rrst[i]});
		end
		apb(1'b0, 10'h3ff, 8'h00);
		chk({r[30:0], e}, 32'h1);
		apb(1'b1, `IDX_CLKDIV, 8'h09);
		for (i = 0; i < 4; i++) begin
			lbl[i] = {2'(i), 1'b1, 4'(rnd()), 1'b0};
			apb(1'b1, 10'(`IDX_LBL_FS + i), lbl[i]);
			apb(1'b0, 10'(`IDX_LBL_FS + i), 8'h00);
			chk(r, {24'h00_0000, lbl[i]});
		end
		for (i = 0; i < 7; i++) run(i);
		chk(rvc[6] - rvc[0] >= 250 && rvc[6] - rvc[0] <= 290, 1);
		chk(rvc[0] >= 2 * rvc[2] - 40 && rvc[0] <= 2 * rvc[2] + 40, 1);
		summarize();
	end
endmodule : tb_top
